// ---- hw/edh_defs.svh ----
// Constants for the EDH framer: packet layout, table map, defaults, timing.
// Assumes inclusion by bare name; holds definitions only.
// How it works
// - Window reads show the last received packet, writes shape the next.
// - Reset low reinitialises control state and all write table defaults.
// - Reset never stalls video; words pass through unprocessed meanwhile.
// - An internal power-on reset does the same initialisation at power-up.
// - Transmit, CRC update off, no packet: no EDH comparison.
// - Transmit with packet inserts a fresh one, flags clear, stream CRCs.
// - CRC update on, no packet: as transmit without packet, any select.
// - CRC update on with packet: no compare, new CRCs, flags kept.
// - Receive, CRC update off, no packet: insert, flags clear, unknown set.
// - Receive, CRC update off, packet: compare CRCs, map flags, reinsert.
// - Every write table bit takes its default whenever the device is reset.
// - Bypass and AP override bits are ORed with their pin, the insert bit ANDed; FF and ANC overrides have no pin.
`ifndef EDH_DEFS_SVH
`define EDH_DEFS_SVH
// Packet data word marking a present EDH packet
`define EDH_DID 10'h1f4
// Word positions inside the EDH slot
`define EDH_W_DID 3'h0
`define EDH_W_APLO 3'h1
`define EDH_W_APHI 3'h2
`define EDH_W_FFLO 3'h3
`define EDH_W_FFHI 3'h4
`define EDH_W_APFL 3'h5
`define EDH_W_FFFL 3'h6
`define EDH_W_ANCFL 3'h7
// Write table addresses and fields
`define EDH_TA_CTRL 2'h0
`define EDH_TA_APOV 2'h1
`define EDH_TA_FFOV 2'h2
`define EDH_TA_ANCOV 2'h3
`define EDH_CTRL_DEF 8'h02
`define EDH_OV_DEF 8'h00
`define EDH_CTRL_BYP 0
`define EDH_CTRL_INS 1
// Flag values and CRC
`define EDH_FL_UES 5'h10
`define EDH_FL_NONE 5'h00
`define EDH_CRC_POLY 16'h1021
`define EDH_CRC_INIT 16'hffff
// Timing
`define EDH_SAFE_LINES 2'h2
`define EDH_CLK_MHZ 250
`define EDH_RST_MIN_NS 100
`define EDH_POR_CYC ((`EDH_RST_MIN_NS * `EDH_CLK_MHZ + 999) / 1000)
`define EDH_FIFO_DEPTH 32
`endif

// ---- hw/edh_pkg.sv ----
// Types shared by the EDH framer modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package edh_pkg;
  // One video word with its timing tags
  typedef struct packed {
    logic [9:0] data;
    logic sof;     // First word of a field
    logic eol;     // Last word of a line
    logic active;  // Active picture word
    logic slot;    // Word lies in the EDH packet slot
  } edh_word_t;

  // One group of EDH error flags
  typedef struct packed {
    logic unknown_error_status_flag;
    logic ida;
    logic idh;
    logic eda;
    logic edh;
  } edh_flags_t;

  // Operating case chosen at the slot start
  typedef enum logic [2:0] {
    EDH_C_OFF,
    EDH_C_TX_NONE,
    EDH_C_TX_PKT,
    EDH_C_CRC_PKT,
    EDH_C_RX_NONE,
    EDH_C_RX_PKT
  } edh_case_t;
endpackage : edh_pkg
`default_nettype wire

// ---- hw/edh_fifo.sv ----
// Output FIFO of the EDH framer, parameterised in width and depth.
// Assumes a single clock; reset is the power-on reset only.
`default_nettype none
module edh_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic por_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] wr_nxt;
  logic [AW:0] rd_r;
  logic [AW:0] rd_nxt;
  logic full;
  logic empty;

  // Pointers carry one extra wrap bit for honest full and empty
  assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty = (wr_r == rd_r);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_r[AW-1:0]];

  // Pointer advance on each handshake
  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (in_valid && !full) begin
      wr_nxt = wr_r + 1'b1;
    end
    if (out_ready && !empty) begin
      rd_nxt = rd_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!por_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Storage needs no reset; only written slots are ever read
  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule : edh_fifo
`default_nettype wire

// ---- hw/edh_table.sv ----
// Host table store: four write-table bytes and a registered read port.
// Assumes the core supplies read-table status bytes, flattened.
`include "edh_defs.svh"
`default_nettype none
module edh_table (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [63:0] status,
  output logic [7:0] rdata,
  output logic [31:0] cfg
);
  logic [7:0] wt_r [4];
  logic [7:0] wt_nxt [4];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Write path; read table half is not writable
  always_comb begin
    wt_nxt = wt_r;
    if (wr_en && !addr[3] && (addr[2] == 1'b0)) begin
      wt_nxt[addr[1:0]] = wdata;
    end
  end

  // Read path; unused write addresses read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      if (addr[3]) begin
        rdata_nxt = status[addr[2:0]*8 +: 8];
      end else if (addr[2] == 1'b0) begin
        rdata_nxt = wt_r[addr[1:0]];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wt_r[`EDH_TA_CTRL] <= `EDH_CTRL_DEF;
      wt_r[`EDH_TA_APOV] <= `EDH_OV_DEF;
      wt_r[`EDH_TA_FFOV] <= `EDH_OV_DEF;
      wt_r[`EDH_TA_ANCOV] <= `EDH_OV_DEF;
      rdata_r <= 8'h00;
    end else begin
      wt_r <= wt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign cfg = {wt_r[3], wt_r[2], wt_r[1], wt_r[0]};
endmodule : edh_table
`default_nettype wire

// ---- hw/edh_core.sv ----
// EDH packet framer: case selection, CRC, flag handling, host window.
// Assumes one video clock; pins from outside are synchronised here.
`include "edh_defs.svh"
`default_nettype none
module edh_core (
  input wire logic clock,
  input wire logic rstn,
  input wire edh_pkg::edh_word_t vid_in,
  input wire logic vid_in_valid,
  output logic vid_in_ready,
  output edh_pkg::edh_word_t vid_out,
  output logic vid_out_valid,
  input wire logic vid_out_ready,
  input wire logic rt_sel,
  input wire logic crc_mode,
  input wire logic bypass_edh,
  input wire logic edh_insert_en,
  input wire logic [4:0] flag_port_in,
  output logic [4:0] flag_port_out,
  output logic host_safe,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata
);
  // Serial CRC over one 10-bit word, most significant bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [9:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 9; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ `EDH_CRC_POLY;
      end
    end
    return r;
  endfunction : crc_step

  // Power-on reset: no reset input, starts from its initial value
  logic [4:0] por_cnt_r = 5'h00;
  logic [4:0] por_cnt_nxt;
  logic por_done;
  logic ctl_rst_n;
  assign por_done = (por_cnt_r == 5'(`EDH_POR_CYC));
  assign ctl_rst_n = rstn && por_done;
  always_comb begin
    por_cnt_nxt = por_done ? por_cnt_r : por_cnt_r + 5'h01;
  end
  always_ff @(posedge clock) begin
    por_cnt_r <= por_cnt_nxt;
  end

  // Two-stage synchronisers for all mode and flag pins
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] pins;
  assign pins = {rt_sel, crc_mode, bypass_edh, edh_insert_en, flag_port_in};
  always_ff @(posedge clock) begin
    if (!ctl_rst_n) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // Host tables
  logic [31:0] cfg;
  logic [63:0] status;
  edh_table u_table (
    .clock(clock),
    .rst_n(ctl_rst_n),
    .wr_en(host_wr),
    .rd_en(host_rd),
    .addr(host_addr),
    .wdata(host_wdata),
    .status(status),
    .rdata(host_rdata),
    .cfg(cfg)
  );

  // Pin and table combination
  logic byp;
  logic ins_en;
  edh_pkg::edh_flags_t ov_ap;
  edh_pkg::edh_flags_t ov_ff;
  edh_pkg::edh_flags_t ov_anc;
  assign byp = cfg[`EDH_CTRL_BYP] | sync2_r[6];
  assign ins_en = cfg[`EDH_CTRL_INS] & sync2_r[5];
  assign ov_ap = cfg[12:8] | sync2_r[4:0];
  assign ov_ff = cfg[20:16];
  assign ov_anc = cfg[28:24];

  // Control state
  logic [1:0] mode_r, mode_nxt;
  edh_pkg::edh_case_t case_r, case_nxt, case_cur;
  logic in_slot_r, in_slot_nxt;
  logic [2:0] idx_r, idx_nxt, idx_cur;
  logic [15:0] crc_ap_r, crc_ap_nxt, crc_ff_r, crc_ff_nxt;
  logic [1:0] mis_r, mis_nxt;
  logic [7:0] rx_r [7], rx_nxt [7];
  logic present_r, present_nxt;
  logic [1:0] lines_r, lines_nxt;
  logic armed_r, armed_nxt, safe_r, safe_nxt;
  logic [4:0] flag_out_r, flag_out_nxt;

  // Datapath stage, reset by power-on only so rstn never stalls it
  edh_pkg::edh_word_t out_r, out_nxt;
  logic out_vld_r, out_vld_nxt;
  logic fifo_ready;
  logic acc;
  assign vid_in_ready = !out_vld_r || fifo_ready;
  assign acc = vid_in_valid && vid_in_ready;

  // Base flags for each case, before overrides
  function automatic edh_pkg::edh_flags_t base_flags(
      input edh_pkg::edh_case_t c, input edh_pkg::edh_flags_t inc,
      input logic mis);
    edh_pkg::edh_flags_t f;
    f = `EDH_FL_NONE;
    case (c)
      edh_pkg::EDH_C_TX_NONE: f = `EDH_FL_NONE;
      edh_pkg::EDH_C_TX_PKT: f = `EDH_FL_NONE;
      edh_pkg::EDH_C_CRC_PKT: f = inc;
      edh_pkg::EDH_C_RX_NONE: f = `EDH_FL_UES;
      edh_pkg::EDH_C_RX_PKT: begin
        // Upstream edh becomes eda downstream; idh, ida and the unknown flag pass unchanged
        f.edh = mis;
        f.eda = inc.edh | inc.eda;
        f.idh = inc.idh;
        f.ida = inc.ida;
        f.unknown_error_status_flag = inc.unknown_error_status_flag;
      end
      default: f = inc;
    endcase
    return f;
  endfunction : base_flags

  // Case at slot start from the field-latched mode and packet presence
  always_comb begin
    idx_cur = in_slot_r ? ((idx_r == `EDH_W_ANCFL) ? idx_r : idx_r + 3'h1)
                        : `EDH_W_DID;
    case_cur = case_r;
    if (idx_cur == `EDH_W_DID) begin
      if (byp || !ins_en) begin
        case_cur = edh_pkg::EDH_C_OFF;
      end else if (vid_in.data != `EDH_DID) begin
        // CRC mode without packet falls back to transmit handling
        case_cur = (mode_r[1] && !mode_r[0]) ? edh_pkg::EDH_C_RX_NONE
                                             : edh_pkg::EDH_C_TX_NONE;
      end else if (mode_r[0]) begin
        case_cur = edh_pkg::EDH_C_CRC_PKT;
      end else begin
        case_cur = mode_r[1] ? edh_pkg::EDH_C_RX_PKT
                             : edh_pkg::EDH_C_TX_PKT;
      end
    end
  end

  // Per-word processing: CRC, comparison, packet rewrite
  always_comb begin
    edh_pkg::edh_flags_t fl;
    fl = `EDH_FL_NONE;
    mode_nxt = mode_r;
    case_nxt = case_r;
    in_slot_nxt = in_slot_r;
    idx_nxt = idx_r;
    crc_ap_nxt = crc_ap_r;
    crc_ff_nxt = crc_ff_r;
    mis_nxt = mis_r;
    rx_nxt = rx_r;
    present_nxt = present_r;
    flag_out_nxt = flag_out_r;
    out_nxt = out_r;
    out_vld_nxt = out_vld_r ? !fifo_ready : 1'b0;
    if (acc) begin
      out_vld_nxt = 1'b1;
      out_nxt = vid_in;
      in_slot_nxt = vid_in.slot;
      if (vid_in.sof) begin
        mode_nxt = {sync2_r[8], sync2_r[7]};
      end
      if (!vid_in.slot) begin
        // Field CRCs restart at each field start
        crc_ff_nxt = crc_step(vid_in.sof ? `EDH_CRC_INIT : crc_ff_r,
                              vid_in.data);
        if (vid_in.sof) begin
          crc_ap_nxt = `EDH_CRC_INIT;
        end
        if (vid_in.active) begin
          crc_ap_nxt = crc_step(vid_in.sof ? `EDH_CRC_INIT : crc_ap_r,
                                vid_in.data);
        end
      end else begin
        idx_nxt = idx_cur;
        case_nxt = case_cur;
        if (idx_cur == `EDH_W_DID) begin
          mis_nxt = 2'b00;
          present_nxt = (vid_in.data == `EDH_DID);
        end
        // Received packet contents kept for the host
        if (present_nxt && idx_cur != `EDH_W_DID) begin
          rx_nxt[idx_cur - 3'h1] = vid_in.data[7:0];
        end
        if (case_cur == edh_pkg::EDH_C_RX_PKT) begin
          // Only receive with a packet compares CRCs
          case (idx_cur)
            `EDH_W_APLO: mis_nxt[0] = vid_in.data[7:0] != crc_ap_r[7:0];
            `EDH_W_APHI: mis_nxt[0] = mis_r[0] |
                                      (vid_in.data[7:0] != crc_ap_r[15:8]);
            `EDH_W_FFLO: mis_nxt[1] = vid_in.data[7:0] != crc_ff_r[7:0];
            `EDH_W_FFHI: mis_nxt[1] = mis_r[1] |
                                      (vid_in.data[7:0] != crc_ff_r[15:8]);
            default: mis_nxt = mis_r;
          endcase
        end
        if (case_cur != edh_pkg::EDH_C_OFF) begin
          case (idx_cur)
            `EDH_W_DID: out_nxt.data = `EDH_DID;
            `EDH_W_APLO: out_nxt.data = {2'b00, crc_ap_r[7:0]};
            `EDH_W_APHI: out_nxt.data = {2'b00, crc_ap_r[15:8]};
            `EDH_W_FFLO: out_nxt.data = {2'b00, crc_ff_r[7:0]};
            `EDH_W_FFHI: out_nxt.data = {2'b00, crc_ff_r[15:8]};
            `EDH_W_APFL: begin
              fl = base_flags(case_cur, vid_in.data[4:0], mis_r[0]) | ov_ap;
              out_nxt.data = {5'h00, fl};
              flag_out_nxt = fl;
            end
            `EDH_W_FFFL: begin
              fl = base_flags(case_cur, vid_in.data[4:0], mis_nxt[1]) |
                   ov_ff;
              out_nxt.data = {5'h00, fl};
            end
            default: begin
              fl = base_flags(case_cur, vid_in.data[4:0], 1'b0) | ov_anc;
              out_nxt.data = {5'h00, fl};
            end
          endcase
        end
      end
      if (!rstn) begin
        out_nxt = vid_in;
      end
    end
  end

  // Safe window counted on words leaving: closed at slot, open 2 lines on
  always_comb begin
    lines_nxt = lines_r;
    armed_nxt = armed_r;
    safe_nxt = safe_r;
    if (out_vld_r && fifo_ready) begin
      if (out_r.slot) begin
        safe_nxt = 1'b0;
        armed_nxt = 1'b1;
        lines_nxt = 2'h0;
      end else if (armed_r && out_r.eol) begin
        lines_nxt = lines_r + 2'h1;
        if (lines_nxt == `EDH_SAFE_LINES) begin
          safe_nxt = 1'b1;
          armed_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!ctl_rst_n) begin
      mode_r <= 2'b00;
      case_r <= edh_pkg::EDH_C_OFF;
      in_slot_r <= 1'b0;
      idx_r <= `EDH_W_DID;
      crc_ap_r <= `EDH_CRC_INIT;
      crc_ff_r <= `EDH_CRC_INIT;
      mis_r <= 2'b00;
      rx_r <= '{default: 8'h00};
      present_r <= 1'b0;
      flag_out_r <= `EDH_FL_NONE;
      lines_r <= 2'h0;
      armed_r <= 1'b0;
      safe_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      case_r <= case_nxt;
      in_slot_r <= in_slot_nxt;
      idx_r <= idx_nxt;
      crc_ap_r <= crc_ap_nxt;
      crc_ff_r <= crc_ff_nxt;
      mis_r <= mis_nxt;
      rx_r <= rx_nxt;
      present_r <= present_nxt;
      flag_out_r <= flag_out_nxt;
      lines_r <= lines_nxt;
      armed_r <= armed_nxt;
      safe_r <= safe_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!por_done) begin
      out_r <= '0;
      out_vld_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      out_vld_r <= out_vld_nxt;
    end
  end

  // Read table: received flags, received CRCs, then live status
  assign status = {2'b00, safe_r, present_r, 1'b0, case_r,
                   rx_r[3], rx_r[2], rx_r[1], rx_r[0],
                   rx_r[6], rx_r[5], rx_r[4]};
  assign flag_port_out = flag_out_r;
  assign host_safe = safe_r;

  // Output buffer; its ready stalls the stage above
  edh_fifo #(
    .WIDTH($bits(edh_pkg::edh_word_t)),
    .DEPTH(`EDH_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .por_n(por_done),
    .in_valid(out_vld_r),
    .in_ready(fifo_ready),
    .in_data(out_r),
    .out_valid(vid_out_valid),
    .out_ready(vid_out_ready),
    .out_data(vid_out)
  );
endmodule : edh_core
`default_nettype wire

// ---- dv/edh_core_sva.sv ----
// Port-level timing checks for the EDH framer top.
// Assumes binding to edh_core; sees only its ports.
`default_nettype none
module edh_core_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire edh_pkg::edh_word_t vid_in,
  input wire logic vid_in_valid,
  input wire logic vid_in_ready,
  input wire edh_pkg::edh_word_t vid_out,
  input wire logic vid_out_valid,
  input wire logic vid_out_ready,
  input wire logic [4:0] flag_port_out,
  input wire logic host_safe,
  input wire logic host_rd,
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_rdata
);
  logic [1:0] eol_cnt_r;
  logic [1:0] eol_cnt_nxt;

  // Lines entered since the last slot word; saturates, reset counts as open
  always_comb begin
    eol_cnt_nxt = eol_cnt_r;
    if (vid_in_valid && vid_in_ready && vid_in.slot) eol_cnt_nxt = 2'h0;
    else if (vid_in_valid && vid_in_ready && vid_in.eol && eol_cnt_r != 2'h3)
      eol_cnt_nxt = eol_cnt_r + 2'h1;
    if (!rstn) eol_cnt_nxt = 2'h3;
  end

  // Registers only
  always_ff @(posedge clock) eol_cnt_r <= eol_cnt_nxt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence slot_in_s;
    vid_in_valid && vid_in_ready && vid_in.slot;
  endsequence
  sequence idle_word_in_s;
    !rstn && vid_in_valid && vid_in_ready && !vid_out_valid;
  endsequence

  reset_clear_a: assert property (disable iff (1'b0)
    $past(!rstn) |-> !host_safe && flag_port_out == 5'h00 &&
    host_rdata == 8'h00)
    else $error("outputs not cleared in reset");
  reset_pass_a: assert property (disable iff (1'b0)
    idle_word_in_s ##0 !$past(vid_in_valid) |->
    ##2 vid_out_valid && vid_out == $past(vid_in, 2))
    else $error("word not passed during reset");
  out_hold_a: assert property (vid_out_valid && !vid_out_ready |=>
    vid_out_valid && $stable(vid_out)) else $error("output word dropped");
  rdata_hold_a: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data changed without read");
  unmapped_rd_a: assert property (host_rd && host_addr[3:2] == 2'h1
    |=> host_rdata == 8'h00) else $error("unmapped read not zero");
  status_rd_a: assert property (host_rd && host_addr == 4'hf |=>
    host_rdata[7:6] == 2'h0 && host_rdata[5] == $past(host_safe) &&
    !host_rdata[3] && host_rdata[2:0] <= 3'h5) else $error("bad status");
  window_shut_a: assert property (slot_in_s |-> ##[1:4] !host_safe)
    else $error("window open over packet");
  window_open_a: assert property ($rose(host_safe) |->
    eol_cnt_r >= 2'h2) else $error("window opened too early");
endmodule : edh_core_sva

bind edh_core edh_core_sva chk (.clock(clock), .rstn(rstn), .vid_in(vid_in),
  .vid_in_valid(vid_in_valid), .vid_in_ready(vid_in_ready),
  .vid_out(vid_out), .vid_out_valid(vid_out_valid),
  .vid_out_ready(vid_out_ready), .flag_port_out(flag_port_out),
  .host_safe(host_safe), .host_rd(host_rd), .host_addr(host_addr),
  .host_rdata(host_rdata));
`default_nettype wire

// ---- dv/edh_sink.sv ----
// Downstream encoder model: accepts output words promptly, slowly or never.
// Assumes the bench picks the pace and captures the words itself.
`default_nettype none
module edh_sink (
  input wire logic clock,
  input wire logic [1:0] pace,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_r;

  initial begin
    ready = 1'b0;
    tick_r = 1'b0;
  end

  // Pace 0 prompt, 1 every other cycle, else stalled
  always @(posedge clock) begin
    tick_r <= !tick_r;
    case (pace)
      2'h0: ready <= 1'b1;
      2'h1: ready <= tick_r;
      default: ready <= 1'b0;
    endcase
  end
endmodule : edh_sink
`default_nettype wire

// ---- dv/edh_mode_and_host_timing_test.sv ----
// Self-checking bench for the EDH framer: cases, host window, reset, FIFO.
// Assumes edh_core, edh_sink and the bound checker are compiled before.
`include "edh_defs.svh"
`default_nettype none
module edh_mode_and_host_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn;
  edh_pkg::edh_word_t vid_in;
  edh_pkg::edh_word_t vid_out;
  logic vid_in_valid, vid_in_ready, vid_out_valid, vid_out_ready;
  logic rt_sel, crc_mode, bypass_edh, edh_insert_en, host_safe;
  logic [4:0] flag_port_in, flag_port_out;
  logic host_wr, host_rd;
  logic [3:0] host_addr;
  logic [7:0] host_wdata, host_rdata, d;
  logic [1:0] pace;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  edh_pkg::edh_word_t outq[$];

  edh_core dut (.clock(clock), .rstn(rstn), .vid_in(vid_in),
    .vid_in_valid(vid_in_valid), .vid_in_ready(vid_in_ready),
    .vid_out(vid_out), .vid_out_valid(vid_out_valid),
    .vid_out_ready(vid_out_ready), .rt_sel(rt_sel), .crc_mode(crc_mode),
    .bypass_edh(bypass_edh), .edh_insert_en(edh_insert_en),
    .flag_port_in(flag_port_in), .flag_port_out(flag_port_out),
    .host_safe(host_safe), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));
  edh_sink sink (.clock(clock), .pace(pace), .ready(vid_out_ready));

  // Clock, word capture at the sink and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (vid_out_valid === 1'b1 && vid_out_ready === 1'b1)
      outq.push_back(vid_out);
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // All drive happens 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : cyc

  task automatic put(input edh_pkg::edh_word_t w);
    int k;
    vid_in = w;
    vid_in_valid = 1'b1;
    k = 0;
    while (vid_in_ready !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    cyc(1);
  endtask : put

  task automatic hwr(input logic [3:0] a, input logic [7:0] v);
    host_addr = a;
    host_wdata = v;
    host_wr = 1'b1;
    cyc(1);
    host_wr = 1'b0;
    cyc(1);
  endtask : hwr

  // Registered data taken one edge after the strobe
  task automatic hrd(input logic [3:0] a, output logic [7:0] v);
    host_addr = a;
    host_rd = 1'b1;
    cyc(1);
    v = host_rdata;
    host_rd = 1'b0;
    cyc(1);
  endtask : hrd

  function automatic logic [15:0] crc_step(input logic [15:0] c,
      input logic [9:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 9; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? `EDH_CRC_POLY : 16'h0000);
    return r;
  endfunction : crc_step

  // One field: two lines, the slot, three short lines
  task automatic one_field(input logic [2:0] m, input logic [4:0] fin,
      input logic [4:0] xap, input logic [4:0] xff, input logic [4:0] xanc,
      input logic thru);
    logic [15:0] ap, ff;
    logic [9:0] sent [8];
    logic [9:0] xw [8];
    logic [9:0] got [$];
    logic [2:0] cs;
    logic bad;
    int k;
    rt_sel = m[2];
    crc_mode = m[1];
    bad = m[2] & !m[1] & m[0];
    cs = !m[0] ? ((m[2] && !m[1]) ? 3'h4 : 3'h1) :
      (m[1] ? 3'h3 : (m[2] ? 3'h5 : 3'h2));
    cyc(4); // Pins pass two sync stages before the field starts
    outq.delete();
    ap = `EDH_CRC_INIT;
    ff = `EDH_CRC_INIT;
    for (int w = 0; w < 8; w++) begin
      put({10'h040 + 10'(w), w == 0, w[1:0] == 2'h3, w[1:0] != 2'h0, 1'b0});
      ff = crc_step(ff, 10'h040 + 10'(w));
      if (w[1:0] != 2'h0) ap = crc_step(ap, 10'h040 + 10'(w));
    end
    sent = '{m[0] ? `EDH_DID : 10'h000, {2'h0, ap[7:0] ^ {7'h0, bad}},
      {2'h0, ap[15:8]}, {2'h0, ff[7:0]}, {2'h0, ff[15:8]},
      {5'h0, fin}, {5'h0, fin}, {5'h0, fin}};
    xw = '{`EDH_DID, {2'h0, ap[7:0]}, {2'h0, ap[15:8]}, {2'h0, ff[7:0]},
      {2'h0, ff[15:8]}, {5'h0, xap}, {5'h0, xff}, {5'h0, xanc}};
    for (int w = 0; w < 8; w++) put({sent[w], 4'h1});
    for (int w = 0; w < 6; w++) put({10'h080, 1'b0, w[0], 2'h0});
    vid_in_valid = 1'b0;
    k = 0;
    while (host_safe !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    cyc(4);
    foreach (outq[i]) if (outq[i].slot) got.push_back(outq[i].data);
    cmp(16'(got.size()), 16'h0008, "slot count");
    for (int w = 0; w < 8; w++) begin
      if (thru) cmp({6'h0, got[w]}, {6'h0, sent[w]}, "thru word");
      else cmp({6'h0, got[w]}, {6'h0, xw[w]}, "slot");
    end
    if (!thru) begin
      hrd(4'hf, d);
      cmp({8'h0, d}, {10'h0, 1'b1, m[0], 1'b0, cs}, "status");
      cmp({11'h0, flag_port_out}, {11'h0, xap}, "flag port");
      if (m[0]) begin
        hrd(4'h8, d);
        cmp({8'h0, d}, {11'h0, fin}, "rx ap flags");
      end
    end
  endtask : one_field

  task automatic t_cases();
    one_field(3'b000, 5'h11, 5'h00, 5'h00, 5'h00, 1'b0);
    one_field(3'b001, 5'h11, 5'h00, 5'h00, 5'h00, 1'b0);
    one_field(3'b010, 5'h11, 5'h00, 5'h00, 5'h00, 1'b0);
    one_field(3'b110, 5'h11, 5'h00, 5'h00, 5'h00, 1'b0);
    one_field(3'b011, 5'h11, 5'h11, 5'h11, 5'h11, 1'b0);
    one_field(3'b100, 5'h11, 5'h10, 5'h10, 5'h10, 1'b0);
    one_field(3'b101, 5'h11, 5'h13, 5'h12, 5'h12, 1'b0);
  endtask : t_cases

  // Window write shapes the next packet; flag pin adds to it
  task automatic t_override();
    hwr({2'h0, `EDH_TA_APOV}, 8'h04);
    hwr(4'h5, 8'hff);
    flag_port_in = 5'h08;
    hrd({2'h0, `EDH_TA_APOV}, d);
    cmp({8'h0, d}, 16'h0004, "ap override");
    hrd(4'h5, d);
    cmp({8'h0, d}, 16'h0000, "unmapped");
    one_field(3'b001, 5'h11, 5'h0c, 5'h00, 5'h00, 1'b0);
    hwr({2'h0, `EDH_TA_APOV}, 8'h00);
    flag_port_in = 5'h00;
  endtask : t_override

  // Bypass pin, insert pin low, then the same two through the table
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      bypass_edh = (i == 0);
      edh_insert_en = (i != 1);
      hwr({2'h0, `EDH_TA_CTRL}, i == 2 ? 8'h03 :
        (i == 3 ? 8'h00 : `EDH_CTRL_DEF));
      one_field(3'b001, 5'h11, 5'h00, 5'h00, 5'h00, 1'b1);
    end
    bypass_edh = 1'b0;
    edh_insert_en = 1'b1;
    hwr({2'h0, `EDH_TA_CTRL}, `EDH_CTRL_DEF);
  endtask : t_pins

  task automatic t_reset();
    hrd({2'h0, `EDH_TA_CTRL}, d);
    cmp({8'h0, d}, {8'h0, `EDH_CTRL_DEF}, "power-up ctrl");
    hwr({2'h0, `EDH_TA_CTRL}, 8'h00);
    hwr({2'h0, `EDH_TA_FFOV}, 8'h1f);
    outq.delete();
    rstn = 1'b0;
    for (int w = 0; w < 6; w++) put({10'h155 + 10'(w), 4'h1});
    vid_in_valid = 1'b0;
    cyc(25);
    rstn = 1'b1;
    hrd({2'h0, `EDH_TA_CTRL}, d);
    cmp({8'h0, d}, {8'h0, `EDH_CTRL_DEF}, "ctrl after reset");
    hrd({2'h0, `EDH_TA_FFOV}, d);
    cmp({8'h0, d}, {8'h0, `EDH_OV_DEF}, "ff ovr after reset");
    cmp(16'(outq.size()), 16'h0006, "reset words");
    foreach (outq[i])
      cmp({2'h0, outq[i]}, {10'h155 + 10'(i), 4'h1}, "rst");
  endtask : t_reset

  // Fill with the sink stalled until refused, then drain slowly
  task automatic t_fifo();
    int n;
    int k;
    n = 0;
    pace = 2'h2;
    cyc(2);
    outq.delete();
    vid_in_valid = 1'b1;
    for (int i = 0; i < 40; i++) begin
      vid_in = {10'h100 + 10'(i), 4'h2};
      if (vid_in_ready !== 1'b1) break;
      cyc(1);
      n++;
    end
    vid_in_valid = 1'b0;
    cmp(16'(n), 16'(`EDH_FIFO_DEPTH + 1), "fill count");
    pace = 2'h1;
    k = 0;
    while (outq.size() < n && k < 500) begin
      cyc(1);
      k++;
    end
    cmp(16'(outq.size()), 16'(n), "drain count");
    foreach (outq[i])
      cmp({6'h0, outq[i].data}, 16'h0100 + 16'(i), "order");
    pace = 2'h0;
  endtask : t_fifo

  initial begin
    rstn = 1'b0;
    vid_in = '0;
    vid_in_valid = 1'b0;
    rt_sel = 1'b0;
    crc_mode = 1'b0;
    bypass_edh = 1'b0;
    edh_insert_en = 1'b1;
    flag_port_in = 5'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 4'h0;
    host_wdata = 8'h00;
    pace = 2'h0;
    cyc(10);
    rstn = 1'b1;
    cyc(30); // Internal power-up reset outlasts the pin reset
    t_reset();
    t_cases();
    t_override();
    t_pins();
    t_fifo();
    stop_test();
  end
endmodule : edh_mode_and_host_timing_test
`default_nettype wire
